// File: tb/serial_gpio_target_link_tb.sv
`timescale 1ns/1ns
module serial_gpio_target_link_tb import sgt_pkg::*;;
    logic        sys_clk_i, nrst_i, psel, penable, pwrite, pready, pslverr;
    logic        lrst, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [11:0] gp_in, led;
    int          mismatches, cmp_count, k, on_n;

    sgt_link_if link ();
    sgt_initiator #(.MIN_HALF(4)) sgt_initiator_inst (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .link(link));
    // Short activity times keep the shaping visible within a few frames.
    sgt_target #(.TIMEOUT(200), .OFF_CYC(40), .MAX_ON_CYC(100),
        .STRETCH_CYC(20)) sgt_target_inst (.sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i), .gp_in_i(gp_in), .led_o(led),
        .link_reset_o(lrst), .link(link));
    sgt_link_asserts sgt_link_asserts_inst (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .sclk(link.sclk),
        .sload(link.sload), .sdout(link.sdout), .din_oe(link.din_oe),
        .link_reset_o(lrst));

    // ======================================================================
    // Clock and tasks
    // ======================================================================
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude

    task automatic chk(input string n, input logic [31:0] x,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask : chk

    // One APB transfer; called just after a rising edge.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk_i) penable <= 1'b1;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 50) begin
            mismatches++;
            conclude();
        end
        @(posedge sys_clk_i);
    endtask : apb

    // Clears the done flag and waits for the frame in flight to end.
    task automatic frame;
        apb(1'b1, STAT_ADDR, 32'h2);
        for (k = 0; k < 100; k++) begin
            apb(1'b0, STAT_ADDR, 32'h0);
            if (q[1] === 1'b1) break;
        end
        if (k == 100) begin
            mismatches++;
            conclude();
        end
    endtask : frame

    // ======================================================================
    // Main sequence
    // ======================================================================
    initial begin
        {nrst_i, psel, penable, pwrite, paddr, pwdata} = '0;
        gp_in = 12'h3c5;
        repeat (6) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        repeat (260) @(posedge sys_clk_i);
        chk("idle_timeout", 1, lrst);
        apb(1'b1, CTRL_ADDR, 32'h1);
        repeat (10) @(posedge sys_clk_i);
        chk("parked_reset", 0, lrst);
        apb(1'b1, DIV_ADDR, 32'h4);
        apb(1'b1, TX_ADDR, 32'h492);
        apb(1'b1, CTRL_ADDR, 32'h3);
        frame();
        frame();
        chk("led_on", 12'h492, led & 12'hdb6);
        apb(1'b0, RX_ADDR, 32'h0);
        chk("rx", {20'h0, gp_in}, q);
        $display("test stream done");
        apb(1'b1, TX_ADDR, 32'h924);
        frame();
        frame();
        // The frame in flight at the write is mixed; one more is awaited.
        frame();
        chk("led_off", 12'h924, led & 12'hdb6);
        apb(1'b1, TX_ADDR, 32'h1);
        frame();
        // Steady activity: lit for the on cap, then dark for the off time.
        for (k = 0; k < 300 && led[0] !== 1'b1; k++) @(posedge sys_clk_i);
        on_n = 0;
        while (led[0] === 1'b1 && on_n < 300) @(posedge sys_clk_i) on_n++;
        chk("act_on_time", 100, on_n);
        on_n = 0;
        while (led[0] === 1'b0 && on_n < 300) @(posedge sys_clk_i) on_n++;
        chk("act_off_time", 40, on_n);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped_err", 1, e);
        chk("unmapped_data", 0, q);
        $display("test activity done");
        apb(1'b1, CTRL_ADDR, 32'h1);
        repeat (200) @(posedge sys_clk_i);
        apb(1'b1, CTRL_ADDR, 32'h0);
        // The mode follows the control write by one edge, the line drivers by two.
        repeat (2) @(posedge sys_clk_i);
        chk("released", 3'b111, {link.sclk, link.sload, link.sdout});
        repeat (260) @(posedge sys_clk_i);
        chk("timeout_leds", {1'b1, 12'h0}, {lrst, led});
        $display("test release done");
        conclude();
    end
endmodule : serial_gpio_target_link_tb

// File: tb/sgt_link_asserts.sv
`timescale 1ns/1ns
module sgt_link_asserts #(
    parameter int TIMEOUT = 200
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic sclk,
    input wire logic sload,
    input wire logic sdout,
    input wire logic din_oe,
    input wire logic link_reset_o
);
    int hi_cnt;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!nrst_i);

    // ======================================================================
    // Idle-line counter
    // ======================================================================
    // Counts cycles with all three initiator lines high at once.
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hi_cnt <= 0;
        end else begin
            hi_cnt <= (sclk && sload && sdout) ? hi_cnt + 1 : 0;
        end
    end

    // ======================================================================
    // Line checks
    // ======================================================================
    AST_RELEASED_AFTER_RESET: assert property ($rose(nrst_i) |-> sclk && sload && sdout)
        else $error("lines not released after reset");
    AST_CLK_HIGH_MIN: assert property ($rose(sclk) |-> sclk[*4])
        else $error("link clock high phase too short");
    AST_CLK_LOW_MIN: assert property ($fell(sclk) |-> !sclk[*4])
        else $error("link clock low phase too short");
    AST_CLK_HIGH_MAX: assert property ($rose(sclk) && !sload |-> ##[1:600] $fell(sclk))
        else $error("link clock high phase too long");
    AST_DATA_HOLD: assert property ($rose(sclk) |=> ($stable(sdout) && $stable(sload))[*3])
        else $error("data moved while link clock high");
    AST_LOAD_FALL_CLK_LOW: assert property ($fell(sload) |-> !sclk)
        else $error("load fell with link clock high");
    AST_TIMEOUT_NOT_EARLY: assert property ($rose(link_reset_o) |-> hi_cnt >= TIMEOUT)
        else $error("link reset raised too early");
    AST_TIMEOUT_TAKEN: assert property (hi_cnt == TIMEOUT + 8 |-> link_reset_o)
        else $error("link reset missing after idle lines");
    AST_TIMEOUT_DROP: assert property (!(sclk && sload && sdout) |-> ##[1:6] !link_reset_o)
        else $error("link reset held with a low line");
    AST_RETURN_ON_LOW: assert property ($changed(din_oe) |-> !sclk || link_reset_o || $past(link_reset_o))
        else $error("return line moved with link clock high");

    // Main scenarios: timeout, frame start and returned data.
    cover property ($rose(link_reset_o));
    cover property ($rose(sclk) && sload);
    cover property ($fell(din_oe));
endmodule : sgt_link_asserts

// File: verilog/sgt_initiator.sv
`timescale 1ns/1ns
module sgt_initiator import sgt_pkg::*; #(
    parameter int NDRV     = NUM_DRIVES,
    parameter int MIN_HALF = CLK_MIN_HALF_CYC,
    parameter int MAX_HALF = CLK_MAX_HALF_CYC
) (
    input  wire logic        sys_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    sgt_link_if.init         link
);
    localparam int NB = NDRV * BITS_PER_DRIVE;
    localparam int IW = $clog2(NB + 1);

    logic [1:0]    ctrl_reg;
    logic [NB-1:0] tx_reg;
    logic [NB-1:0] rx_reg;
    logic [31:0]   div_reg;
    logic          done_reg;
    sgt_mode_type  mode_reg;
    logic [31:0]   half_reg;
    logic [IW-1:0] bit_reg;
    logic          clk_low_reg;
    logic          load_low_reg;
    logic          dout_low_reg;
    logic [2:0]    din_sync_reg;
    logic          din_reg;
    logic          wr_en;
    logic          half_end;
    logic          last_bit;
    logic          frame_end;
    logic          din_now;

    // Keeps the divider inside the legal clock band of the link.
    function automatic logic [31:0] clamp_half(input logic [31:0] v);
        if (v < 32'(MIN_HALF)) return 32'(MIN_HALF);
        if (v > 32'(MAX_HALF)) return 32'(MAX_HALF);
        return v;
    endfunction : clamp_half

    // ======================================================================
    // Register bus, zero wait states
    // ======================================================================
    assign wr_en = psel_i & penable_i & pready_o & pwrite_i;

    // Answer is prepared in the setup cycle and stands for the access.
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0;
        end else begin
            pready_o  <= psel_i & ~penable_i;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0;
            if (psel_i && !penable_i) begin
                unique case (paddr_i)
                    CTRL_ADDR: prdata_o <= 32'(ctrl_reg);
                    TX_ADDR:   prdata_o <= 32'(tx_reg);
                    RX_ADDR:   prdata_o <= 32'(rx_reg);
                    DIV_ADDR:  prdata_o <= div_reg;
                    STAT_ADDR: prdata_o <= 32'({done_reg,
                                       mode_reg == MODE_STREAM});
                    default:   pslverr_o <= 1'b1;
                endcase
            end
        end
    end

    // Software writes; the divider is clamped as it is stored.
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_reg <= 2'h0;
            tx_reg   <= '0;
            div_reg  <= 32'(MIN_HALF);
        end else if (wr_en) begin
            if (paddr_i == CTRL_ADDR) ctrl_reg <= pwdata_i[1:0];
            if (paddr_i == TX_ADDR)   tx_reg   <= pwdata_i[NB-1:0];
            if (paddr_i == DIV_ADDR)  div_reg  <= clamp_half(pwdata_i);
        end
    end

    // Frame-done flag: a completing frame wins over a clearing write.
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            done_reg <= 1'b0;
        end else if (frame_end) begin
            done_reg <= 1'b1;
        end else if (wr_en && paddr_i == STAT_ADDR &&
                     pwdata_i[STAT_DONE_BIT]) begin
            done_reg <= 1'b0;
        end
    end

    // ======================================================================
    // Returned data line
    // ======================================================================
    // Three stages; the level only moves when the last two agree.
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            din_sync_reg <= 3'h7;
            din_reg      <= 1'b1;
        end else begin
            din_sync_reg <= {din_sync_reg[1:0], link.sdin};
            if (din_sync_reg[1] == din_sync_reg[2]) din_reg <= din_sync_reg[2];
        end
    end

    // Sampling takes the agreeing stages directly, one cycle ahead of the
    // filtered level. A bit driven at the falling edge is then caught even
    // at the shortest half period.
    assign din_now = (din_sync_reg[1] == din_sync_reg[2]) ? din_sync_reg[2]
                                                          : din_reg;

    // ======================================================================
    // Bit engine
    // ======================================================================
    assign half_end  = (half_reg >= div_reg - 32'h1);
    assign last_bit  = (bit_reg == IW'(NB - 1));
    assign frame_end = (mode_reg == MODE_STREAM) & half_end & ~clk_low_reg
                       & last_bit;

    // A stream always runs whole frames of NDRV drives; a
    // dropped present bit cuts it at once and frees the lines.
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode_reg     <= MODE_RELEASED;
            half_reg     <= 32'h0;
            bit_reg      <= '0;
            clk_low_reg  <= 1'b0;
            load_low_reg <= 1'b0;
            dout_low_reg <= 1'b0;
            rx_reg       <= '0;
        end else begin
            unique case (mode_reg)
                MODE_RELEASED: begin
                    clk_low_reg  <= 1'b0;
                    load_low_reg <= 1'b0;
                    dout_low_reg <= 1'b0;
                    if (ctrl_reg[CTRL_PRESENT_BIT]) mode_reg <= MODE_PARKED;
                end
                MODE_PARKED: begin
                    clk_low_reg  <= 1'b1;
                    load_low_reg <= 1'b1;
                    dout_low_reg <= 1'b0;
                    half_reg     <= 32'h0;
                    if (!ctrl_reg[CTRL_PRESENT_BIT]) begin
                        mode_reg <= MODE_RELEASED;
                    end else if (ctrl_reg[CTRL_RUN_BIT]) begin
                        mode_reg     <= MODE_STREAM;
                        bit_reg      <= '0;
                        load_low_reg <= 1'b0;
                        dout_low_reg <= ~tx_reg[0];
                    end
                end
                MODE_STREAM: begin
                    half_reg <= half_end ? 32'h0 : half_reg + 32'h1;
                    if (!ctrl_reg[CTRL_PRESENT_BIT]) begin
                        mode_reg <= MODE_RELEASED;
                    end else if (half_end && clk_low_reg) begin
                        rx_reg[bit_reg] <= din_now;
                        clk_low_reg     <= 1'b0;
                    end else if (half_end) begin
                        clk_low_reg <= 1'b1;
                        if (last_bit && !ctrl_reg[CTRL_RUN_BIT]) begin
                            mode_reg <= MODE_PARKED;
                        end else if (last_bit) begin
                            bit_reg      <= '0;
                            load_low_reg <= 1'b0;
                            dout_low_reg <= ~tx_reg[0];
                        end else begin
                            bit_reg      <= bit_reg + IW'(1);
                            load_low_reg <= 1'b1;
                            dout_low_reg <= ~tx_reg[bit_reg + IW'(1)];
                        end
                    end
                end
            endcase
        end
    end

    // Open drain: the enables carry the line, the driven value is low.
    assign link.clk_o   = 1'b0;
    assign link.load_o  = 1'b0;
    assign link.dout_o  = 1'b0;
    assign link.clk_oe  = clk_low_reg;
    assign link.load_oe = load_low_reg;
    assign link.dout_oe = dout_low_reg;

endmodule : sgt_initiator

// File: verilog/sgt_link_if.sv
`timescale 1ns/1ns
// Open-drain link: each line has one driving end and is low while that end enables its driver.
interface sgt_link_if;
    logic clk_o;
    logic clk_oe;
    logic load_o;
    logic load_oe;
    logic dout_o;
    logic dout_oe;
    logic din_o;
    logic din_oe;
    logic sclk;
    logic sload;
    logic sdout;
    logic sdin;

    // ======================================================================
    // Wire resolution with pull-ups
    // ======================================================================
    assign sclk  = clk_oe  ? clk_o  : 1'b1;
    assign sload = load_oe ? load_o : 1'b1;
    assign sdout = dout_oe ? dout_o : 1'b1;
    assign sdin  = din_oe  ? din_o  : 1'b1;

    modport init (output clk_o, clk_oe, load_o, load_oe, dout_o, dout_oe,
                  input sdin);
    modport tgt  (input sclk, sload, sdout, output din_o, din_oe);
endinterface : sgt_link_if

// File: verilog/sgt_pkg.sv
package sgt_pkg;

    // ======================================================================
    // Link timing
    // ======================================================================
    localparam int SYS_CLK_KHZ       = 100000;
    localparam int SYS_CLK_MHZ       = SYS_CLK_KHZ / 1000;
    localparam int TIMEOUT_MS        = 64;
    localparam int TIMEOUT_CYC       = TIMEOUT_MS * SYS_CLK_KHZ;
    localparam int CLK_MAX_PERIOD_US = 31250;
    localparam int CLK_MAX_HALF_CYC  = (CLK_MAX_PERIOD_US * SYS_CLK_MHZ) / 2;
    localparam int CLK_MAX_KHZ       = 100;
    localparam int CLK_MIN_HALF_CYC  =
        (SYS_CLK_KHZ + 2 * CLK_MAX_KHZ - 1) / (2 * CLK_MAX_KHZ);

    // ======================================================================
    // Activity indicator timing
    // ======================================================================
    localparam int ACT_OFF_US        = 125000;
    localparam int ACT_OFF_CYC       = ACT_OFF_US * SYS_CLK_MHZ;
    localparam int ACT_MAX_ON_US     = 500000;
    localparam int ACT_MAX_ON_CYC    = ACT_MAX_ON_US * SYS_CLK_MHZ;
    localparam int ACT_STRETCH_US    = 15625;
    localparam int ACT_STRETCH_CYC   = ACT_STRETCH_US * SYS_CLK_MHZ;
    localparam int CNT_W             = 26;

    // ======================================================================
    // Stream layout
    // ======================================================================
    localparam int NUM_DRIVES        = 4;
    localparam int BITS_PER_DRIVE    = 3;
    localparam int ACT_BIT           = 0;
    localparam int LOC_BIT           = 1;
    localparam int FAIL_BIT          = 2;

    // ======================================================================
    // Initiator registers
    // ======================================================================
    localparam logic [7:0] CTRL_ADDR   = 8'h00;
    localparam logic [7:0] TX_ADDR     = 8'h04;
    localparam logic [7:0] RX_ADDR     = 8'h08;
    localparam logic [7:0] DIV_ADDR    = 8'h0c;
    localparam logic [7:0] STAT_ADDR   = 8'h10;
    localparam int CTRL_PRESENT_BIT    = 0;
    localparam int CTRL_RUN_BIT        = 1;
    localparam int STAT_STREAM_BIT     = 0;
    localparam int STAT_DONE_BIT       = 1;

    typedef enum logic [1:0] {
        MODE_RELEASED,
        MODE_PARKED,
        MODE_STREAM
    } sgt_mode_type;

endpackage : sgt_pkg

// File: verilog/sgt_target.sv
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ns
module sgt_target import sgt_pkg::*; #(
    parameter int NDRV        = NUM_DRIVES,
    parameter int TIMEOUT     = TIMEOUT_CYC,
    parameter int OFF_CYC     = ACT_OFF_CYC,
    parameter int MAX_ON_CYC  = ACT_MAX_ON_CYC,
    parameter int STRETCH_CYC = ACT_STRETCH_CYC,
    parameter int NB          = NDRV * BITS_PER_DRIVE
) (
    input  wire logic          sys_clk_i,
    input  wire logic          nrst_i,
    input  wire logic [NB-1:0] gp_in_i,
    output logic      [NB-1:0] led_o,
    output logic               link_reset_o,
    sgt_link_if.tgt            link
);
    localparam int IW = $clog2(NB + 1);
    localparam int TW = $clog2(TIMEOUT + 1);

    // Link domain, clocked by the initiator's clock line.
    logic          link_rst_n;
    logic [IW-1:0] idx_reg;
    logic [NB-1:0] shadow_reg;
    logic [NB-1:0] hold_reg;
    logic          hold_tgl_reg;
    logic [NB-1:0] gp_s1_reg;
    logic [NB-1:0] gp_s2_reg;
    logic [NB-1:0] gp_s3_reg;
    logic [NB-1:0] gp_link_reg;
    logic          din_low_reg;

    // System domain.
    logic [2:0]    pin_s1_reg;
    logic [2:0]    pin_s2_reg;
    logic [2:0]    pin_s3_reg;
    logic [2:0]    pin_reg;
    logic [TW-1:0] idle_cnt_reg;
    logic          timeout_reg;
    logic [2:0]    tgl_sync_reg;
    logic          tgl_seen_reg;
    logic [NB-1:0] frame_reg;
    logic [NB-1:0] ind_reg;
    logic [NDRV-1:0]  act_led_reg;
    logic [NDRV-1:0]  act_prev_reg;
    logic [CNT_W-1:0] stretch_reg [NDRV];
    logic [CNT_W-1:0] on_reg      [NDRV];
    logic [CNT_W-1:0] off_reg     [NDRV];

    // ======================================================================
    // Link domain framing
    // ======================================================================
    // The timeout resets the link side asynchronously, because the link
    // clock has stopped when it fires.
    assign link_rst_n = nrst_i & ~timeout_reg;

    // Bits are taken on the rising edge. A load marker starts a new
    // stream wherever it falls; the previous one is handed over only if
    // it reached full length, so a cut stream never reaches the LEDs.
    always_ff @(posedge link.sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            idx_reg      <= IW'(NB);
            shadow_reg   <= '0;
            hold_reg     <= '0;
            hold_tgl_reg <= 1'b0;
        end else if (link.sload) begin
            if (idx_reg == IW'(NB)) begin
                hold_reg     <= shadow_reg;
                hold_tgl_reg <= ~hold_tgl_reg;
            end
            shadow_reg[0] <= link.sdout;
            idx_reg       <= IW'(1);
        end else if (idx_reg < IW'(NB)) begin
            shadow_reg[idx_reg] <= link.sdout;
            idx_reg             <= idx_reg + IW'(1);
        end
    end

    // General inputs enter the link domain through three stages; a bit
    // only moves when the last two agree.
    always_ff @(posedge link.sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            gp_s1_reg   <= '0;
            gp_s2_reg   <= '0;
            gp_s3_reg   <= '0;
            gp_link_reg <= '0;
        end else begin
            gp_s1_reg   <= gp_in_i;
            gp_s2_reg   <= gp_s1_reg;
            gp_s3_reg   <= gp_s2_reg;
            gp_link_reg <= (gp_s2_reg & gp_s3_reg)
                         | (gp_link_reg & (gp_s2_reg | gp_s3_reg));
        end
    end

    // Returned bit for the current slot is driven at the falling edge so
    // it is settled long before the initiator samples it. Past the end of
    // the stream bit 0 is presented ahead of the next marker.
    always_ff @(negedge link.sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            din_low_reg <= 1'b0;
        end else if (idx_reg == IW'(NB)) begin
            din_low_reg <= ~gp_link_reg[0];
        end else begin
            din_low_reg <= ~gp_link_reg[idx_reg];
        end
    end

    assign link.din_o  = 1'b0;
    assign link.din_oe = din_low_reg;

    // ======================================================================
    // Inactivity timeout
    // ======================================================================
    // Line levels pass three stages; a change counts once two agree.
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_s1_reg <= 3'h7;
            pin_s2_reg <= 3'h7;
            pin_s3_reg <= 3'h7;
            pin_reg    <= 3'h7;
        end else begin
            pin_s1_reg <= {link.sclk, link.sload, link.sdout};
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            pin_reg    <= (pin_s2_reg & pin_s3_reg)
                        | (pin_reg & (pin_s2_reg | pin_s3_reg));
        end
    end

    // The returned data line plays no part here; only the three lines
    // that the initiator drives are watched.
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            idle_cnt_reg <= '0;
            timeout_reg  <= 1'b0;
        end else if (!(&pin_reg)) begin
            idle_cnt_reg <= '0;
            timeout_reg  <= 1'b0;
        end else if (idle_cnt_reg < TW'(TIMEOUT - 1)) begin
            idle_cnt_reg <= idle_cnt_reg + TW'(1);
        end else begin
            timeout_reg <= 1'b1;
        end
    end

    assign link_reset_o = timeout_reg;

    // ======================================================================
    // Frame hand-over into the system domain
    // ======================================================================
    // The held word is stable for a whole stream after the toggle, far
    // longer than the synchroniser delay, so it is copied without care.
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tgl_sync_reg <= 3'h0;
            tgl_seen_reg <= 1'b0;
            frame_reg    <= '0;
        end else if (timeout_reg) begin
            tgl_sync_reg <= {tgl_sync_reg[1:0], hold_tgl_reg};
            tgl_seen_reg <= 1'b0;
            frame_reg    <= '0;
        end else begin
            tgl_sync_reg <= {tgl_sync_reg[1:0], hold_tgl_reg};
            if (tgl_sync_reg[1] == tgl_sync_reg[2] &&
                tgl_sync_reg[2] != tgl_seen_reg) begin
                tgl_seen_reg <= tgl_sync_reg[2];
                frame_reg    <= hold_reg;
            end
        end
    end

    // ======================================================================
    // Indicator drive
    // ======================================================================
    // Locate and fail bits drive their LEDs directly; they are
    // taken as they come, never checked.
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ind_reg <= '0;
        end else begin
            ind_reg <= frame_reg;
        end
    end

    // Activity shaping per drive. A rising activity bit arms the stretch
    // so a one-frame pulse outside the forced dark is seen; a light held too long is forced
    // dark for a while so steady traffic still reads as blinking.
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            act_led_reg  <= '0;
            act_prev_reg <= '0;
            for (int d = 0; d < NDRV; d++) begin
                stretch_reg[d] <= '0;
                on_reg[d]      <= '0;
                off_reg[d]     <= '0;
            end
        end else begin
            for (int d = 0; d < NDRV; d++) begin
                act_prev_reg[d] <= frame_reg[d*BITS_PER_DRIVE + ACT_BIT];
                if (off_reg[d] != '0) begin
                    off_reg[d]     <= off_reg[d] - CNT_W'(1);
                    on_reg[d]      <= '0;
                    stretch_reg[d] <= '0;
                    act_led_reg[d] <= 1'b0;
                end else if (frame_reg[d*BITS_PER_DRIVE + ACT_BIT] ||
                             stretch_reg[d] != '0) begin
                    act_led_reg[d] <= 1'b1;
                    if (frame_reg[d*BITS_PER_DRIVE + ACT_BIT] &&
                        !act_prev_reg[d]) begin
                        stretch_reg[d] <= CNT_W'(STRETCH_CYC - 1);
                    end else if (stretch_reg[d] != '0) begin
                        stretch_reg[d] <= stretch_reg[d] - CNT_W'(1);
                    end
                    if (on_reg[d] >= CNT_W'(MAX_ON_CYC - 1)) begin
                        off_reg[d] <= CNT_W'(OFF_CYC);
                        on_reg[d]  <= '0;
                    end else begin
                        on_reg[d] <= on_reg[d] + CNT_W'(1);
                    end
                end else begin
                    act_led_reg[d] <= 1'b0;
                    on_reg[d]      <= '0;
                end
            end
        end
    end

    // Output assembly: every bit is a flop, activity taken from shaping.
    always_comb begin
        led_o = ind_reg;
        for (int d = 0; d < NDRV; d++) begin
            led_o[d*BITS_PER_DRIVE + ACT_BIT] = act_led_reg[d];
        end
    end

endmodule : sgt_target
